// [design/aec_top.v]
// Acquisition engine control registers and nested window sequencer
//
// Chosen here: the strobed register port and the address map.
`include "aec_consts.vh"
// Notes on behaviour
// RL1 - Writing run-level bits 3:0 changes the commanded run level at once.
// RL2 - Reading run level returns last command, not the sequencer state.
// RL3 - Codes: 0 idle, 1 run, 2..5 stop after volume/frame/line/block.
// RL4 - Each stop happens only on a clean boundary of its own unit.
// RL5 - Writing 1 to bit 9 zeroes all four acquired counters.
// RL6 - Status bits 2:0 show live nesting level, idle up to line.
// RL7 - Packet FIFO overflow sets status bit 4 and aborts acquisition.
// RL8 - Source field 7:0 picks stream aggregator; only 0 to 3 work.
// RL9 - Software sets source to its virtual frame grabber number.
// RL10 - Source bit 31 selects the synthetic frame generator.
// RL11 - Volume total bits 15:0 sets volumes; 0xffff runs forever.
// RL12 - With infinite total, software stops by writing run level.
// RL13 - Volume total writes take effect only while state reads idle.
// RL14 - Volume window control holds seven four-bit fields, 31:28 reserved.
// RL15 - Legacy snap/grab/freeze/abort map onto sizes and run levels.
// RL16 - Trigger function: rise, fall, high, low, either edge.
// RL17 - Close mode 0 after N frames; mode 1 trigger then frame end.
// RL18 - Open mode 0 at once; mode 1 waits for trigger condition.
// RL19 - Sync 1 drops pixels before each start of frame marker.
// RL20 - Reserved bits read zero and ignore writes.
module aec_top (
   input  wire        ref_clk_in,
   input  wire        rst_in,
   input  wire [7:0]  reg_addr_in,
   input  wire [31:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [31:0] reg_rdata_out,
   input  wire [3:0]  strm_valid_in,
   input  wire [3:0]  strm_sof_in,
   input  wire [3:0]  strm_sol_in,
   input  wire [127:0] strm_data_in,
   input  wire        synth_valid_in,
   input  wire        synth_sof_in,
   input  wire        synth_sol_in,
   input  wire [31:0] synth_data_in,
   input  wire [4:0]  trig_in,
   input  wire [15:0] frames_per_volume_in,
   input  wire [15:0] lines_per_frame_in,
   input  wire [15:0] pixels_per_line_in,
   input  wire        packet_fifo_overflow_in,
   output reg         pix_valid_out,
   output reg  [31:0] pix_data_out,
   output reg  [31:0] volumes_acquired_counter_out,
   output reg  [31:0] frames_acquired_counter_out,
   output reg  [31:0] lines_acquired_counter_out,
   output reg  [31:0] pixels_acquired_counter_out,
   output reg  [2:0]  engine_nesting_state_out
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_VSEQ = 5'h02;
   localparam [4:0] S_VOL  = 5'h04;
   localparam [4:0] S_FRM  = 5'h08;
   localparam [4:0] S_LINE = 5'h10;

   reg  [3:0]  run_level_command_q;
   reg  [7:0]  src_sel_q;
   reg         use_synth_q;
   reg  [15:0] vol_total_q;
   reg  [27:0] vwin_q;
   reg         packet_fifo_overflow_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [15:0] vol_cnt_q;
   reg  [15:0] frm_cnt_q;
   reg  [15:0] line_cnt_q;
   reg  [15:0] pix_cnt_q;
   reg  [4:0]  blk_beat_q;
   reg         close_pend_q;
   reg  [2:0]  state_code;

   wire wr_run  = reg_wr_in & (reg_addr_in == `AEC_OFS_RUN_CTRL);
   wire wr_src  = reg_wr_in & (reg_addr_in == `AEC_OFS_SRC_SEL);
   wire wr_vol  = reg_wr_in & (reg_addr_in == `AEC_OFS_VOL_CFG);
   wire wr_vwin = reg_wr_in & (reg_addr_in == `AEC_OFS_VWIN_CTRL);
   // Start is the write itself, so a finished run does not relaunch
   wire start_req = wr_run &
                    (reg_wdata_in[3:0] == `AEC_CMD_RUN);
   wire clr_cnt = wr_run & reg_wdata_in[`AEC_CLR_BIT];

   wire [3:0] close_fn   = vwin_q[`AEC_CLOSE_FN_LSB +: 4];
   wire [3:0] close_sel  = vwin_q[`AEC_CLOSE_SEL_LSB +: 4];
   wire [3:0] close_mode = vwin_q[`AEC_CLOSE_MODE_LSB +: 4];
   wire [3:0] open_fn    = vwin_q[`AEC_OPEN_FN_LSB +: 4];
   wire [3:0] open_sel   = vwin_q[`AEC_OPEN_SEL_LSB +: 4];
   wire [3:0] open_mode  = vwin_q[`AEC_OPEN_MODE_LSB +: 4];
   wire [3:0] sync_mode  = vwin_q[`AEC_SYNC_LSB +: 4];

   wire open_hit;
   wire close_hit;

   aec_trig u_open_trig (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .trig_in    (trig_in),
      .sel_in     (open_sel),
      .func_in    (open_fn),
      .hit_out    (open_hit)
   );

   aec_trig u_close_trig (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .trig_in    (trig_in),
      .sel_in     (close_sel),
      .func_in    (close_fn),
      .hit_out    (close_hit)
   );

   // Source mux; unsupported aggregator numbers deliver nothing
   wire        src_ok = (src_sel_q < 8'h04); // see RL8
   wire [1:0]  sidx   = src_sel_q[1:0];
   wire        s_valid = use_synth_q ? synth_valid_in : // see RL10
                         (src_ok & strm_valid_in[sidx]);
   wire        s_sof  = use_synth_q ? synth_sof_in : strm_sof_in[sidx];
   wire        s_sol  = use_synth_q ? synth_sol_in : strm_sol_in[sidx];
   wire [31:0] s_data = use_synth_q ? synth_data_in :
                        strm_data_in[{sidx, 5'h00} +: 32];

   // Stop points per granularity; codes above 5 behave as idle
   wire cmd_run  = (run_level_command_q == `AEC_CMD_RUN); // see RL3
   wire stop_vol = ~cmd_run &
                   (run_level_command_q != `AEC_CMD_ABORT_V);
   wire stop_frm = stop_vol &
                   (run_level_command_q != `AEC_CMD_ABORT_Z);
   wire stop_blk = stop_frm &
                   (run_level_command_q != `AEC_CMD_ABORT_Y);

   wire vols_done  = (vol_total_q != `AEC_VOL_INFINITE) &
                     (vol_cnt_q >= vol_total_q); // see RL11
   wire frms_done  = (frm_cnt_q >= frames_per_volume_in);
   wire lines_done = (line_cnt_q >= lines_per_frame_in);
   wire last_pix   = ({16'h0000, pix_cnt_q} + 32'h1) >=
                     {16'h0000, pixels_per_line_in};
   wire vol_close  = (close_mode == `AEC_MODE_TRIG) ? close_pend_q :
                     frms_done; // see RL17

   wire take_first = (state_q == S_FRM) & ~lines_done & ~stop_frm &
                     s_valid & s_sol;
   wire take_pix   = take_first | ((state_q == S_LINE) & s_valid);
   wire blk_end    = (blk_beat_q == `AEC_BLK_BEATS_M1);

   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (start_req)
               state_d = S_VSEQ;
         end
         S_VSEQ: begin
            if (~cmd_run | vols_done) // see RL4
               state_d = S_IDLE;
            else if (open_mode != `AEC_MODE_TRIG | open_hit) // see RL18
               state_d = S_VOL;
         end
         S_VOL: begin
            if (vol_close)
               state_d = S_VSEQ;
            else if (stop_vol) // see RL4
               state_d = S_IDLE;
            else if (sync_mode != `AEC_SYNC_SOF | (s_valid & s_sof))
               state_d = S_FRM; // see RL19
         end
         S_FRM: begin
            if (lines_done)
               state_d = S_VOL;
            else if (stop_frm) // see RL4
               state_d = S_IDLE;
            else if (take_first)
               state_d = last_pix ? S_FRM : S_LINE;
         end
         S_LINE: begin
            if (s_valid & last_pix)
               state_d = S_FRM;
            else if (stop_blk & s_valid & blk_end) // see RL4
               state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
      if (packet_fifo_overflow_in)
         state_d = S_IDLE; // see RL7
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_q      <= S_IDLE;
         vol_cnt_q    <= 16'h0000;
         frm_cnt_q    <= 16'h0000;
         line_cnt_q   <= 16'h0000;
         pix_cnt_q    <= 16'h0000;
         blk_beat_q   <= 5'h00;
         close_pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == S_IDLE)
            vol_cnt_q <= 16'h0000;
         else if (state_q == S_VOL && state_d == S_VSEQ)
            vol_cnt_q <= vol_cnt_q + 16'h0001;
         if (state_q == S_VSEQ)
            frm_cnt_q <= 16'h0000;
         else if (state_q == S_FRM && state_d == S_VOL)
            frm_cnt_q <= frm_cnt_q + 16'h0001;
         if (state_q == S_VOL)
            line_cnt_q <= 16'h0000;
         else if (take_pix && last_pix)
            line_cnt_q <= line_cnt_q + 16'h0001;
         if (take_pix && last_pix)
            pix_cnt_q <= 16'h0000;
         else if (take_pix)
            pix_cnt_q <= pix_cnt_q + 16'h0001;
         if (take_pix && last_pix)
            blk_beat_q <= 5'h00;
         else if (take_pix)
            blk_beat_q <= blk_beat_q + 5'h01;
         // Close trigger is remembered until the volume closes or the engine goes idle
         if (state_q == S_VSEQ || state_q == S_IDLE)
            close_pend_q <= 1'b0;
         else if (close_mode == `AEC_MODE_TRIG && close_hit)
            close_pend_q <= 1'b1; // see RL17
      end
   end

   // Acquired counters and pixel output
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         volumes_acquired_counter_out <= 32'h0;
         frames_acquired_counter_out  <= 32'h0;
         lines_acquired_counter_out   <= 32'h0;
         pixels_acquired_counter_out  <= 32'h0;
         pix_valid_out <= 1'b0;
         pix_data_out  <= 32'h0;
      end else begin
         pix_valid_out <= take_pix;
         if (take_pix)
            pix_data_out <= s_data;
         if (clr_cnt) begin // see RL5
            volumes_acquired_counter_out <= 32'h0;
            frames_acquired_counter_out  <= 32'h0;
            lines_acquired_counter_out   <= 32'h0;
            pixels_acquired_counter_out  <= 32'h0;
         end else begin
            if (state_q == S_VOL && state_d == S_VSEQ)
               volumes_acquired_counter_out <=
                  volumes_acquired_counter_out + 32'h1;
            if (state_q == S_FRM && state_d == S_VOL)
               frames_acquired_counter_out <=
                  frames_acquired_counter_out + 32'h1;
            if (take_pix && last_pix)
               lines_acquired_counter_out <=
                  lines_acquired_counter_out + 32'h1;
            if (take_pix)
               pixels_acquired_counter_out <=
                  pixels_acquired_counter_out + 32'h1;
         end
      end
   end

   always @* begin
      case (state_d)
         S_VSEQ:  state_code = `AEC_ST_VSEQ;
         S_VOL:   state_code = `AEC_ST_VOL;
         S_FRM:   state_code = `AEC_ST_FRM;
         S_LINE:  state_code = `AEC_ST_LINE;
         default: state_code = `AEC_ST_IDLE;
      endcase
   end

   // Register file
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         run_level_command_q    <= `AEC_CMD_IDLE;
         src_sel_q              <= 8'h00;
         use_synth_q            <= 1'b0;
         vol_total_q            <= `AEC_VOL_TOTAL_RST;
         vwin_q                 <= 28'h0000000;
         packet_fifo_overflow_q <= 1'b0;
         engine_nesting_state_out <= `AEC_ST_IDLE;
      end else begin
         engine_nesting_state_out <= state_code; // see RL6
         if (wr_run)
            run_level_command_q <= reg_wdata_in[3:0]; // see RL1
         if (wr_src) begin
            src_sel_q   <= reg_wdata_in[7:0]; // see RL8
            use_synth_q <= reg_wdata_in[`AEC_SYNTH_BIT]; // see RL10
         end
         // Discarded unless the engine reads idle
         if (wr_vol && engine_nesting_state_out == `AEC_ST_IDLE)
            vol_total_q <= reg_wdata_in[15:0]; // see RL13
         if (wr_vwin)
            vwin_q <= reg_wdata_in[27:0]; // see RL14
         // Overflow flag cleared by a run start; a new overflow wins
         if (packet_fifo_overflow_in)
            packet_fifo_overflow_q <= 1'b1; // see RL7
         else if (start_req)
            packet_fifo_overflow_q <= 1'b0;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h0;
      end else if (reg_rd_in) begin
         case (reg_addr_in) // see RL20
            `AEC_OFS_RUN_CTRL:
               reg_rdata_out <= {28'h0, run_level_command_q}; // see RL2
            `AEC_OFS_STATUS:
               reg_rdata_out <= {27'h0, packet_fifo_overflow_q, 1'b0,
                                 engine_nesting_state_out};
            `AEC_OFS_SRC_SEL:
               reg_rdata_out <= {use_synth_q, 23'h0, src_sel_q};
            `AEC_OFS_VOL_CFG:
               reg_rdata_out <= {16'h0, vol_total_q};
            `AEC_OFS_VWIN_CTRL:
               reg_rdata_out <= {4'h0, vwin_q};
            default:
               reg_rdata_out <= 32'h0;
         endcase
      end else begin
         reg_rdata_out <= 32'h0;
      end
   end
endmodule // aec_top

// [design/aec_consts.vh]
// Constants for the acquisition engine control block
`ifndef AEC_CONSTS_VH
`define AEC_CONSTS_VH
`define AEC_ADDR_W          8
`define AEC_OFS_RUN_CTRL    8'h00
`define AEC_OFS_STATUS      8'h04
`define AEC_OFS_SRC_SEL     8'h08
`define AEC_OFS_VOL_CFG     8'h0c
`define AEC_OFS_VWIN_CTRL   8'h10
`define AEC_CMD_IDLE        4'h0
`define AEC_CMD_RUN         4'h1
`define AEC_CMD_ABORT_V     4'h2
`define AEC_CMD_ABORT_Z     4'h3
`define AEC_CMD_ABORT_Y     4'h4
`define AEC_CMD_ABORT_X     4'h5
`define AEC_CLR_BIT         9
`define AEC_OVF_BIT         4
`define AEC_SYNTH_BIT       31
`define AEC_ST_IDLE         3'h0
`define AEC_ST_VSEQ         3'h1
`define AEC_ST_VOL          3'h2
`define AEC_ST_FRM          3'h3
`define AEC_ST_LINE         3'h4
`define AEC_VOL_INFINITE    16'hffff
`define AEC_VOL_TOTAL_RST   16'h0001
`define AEC_BLK_BEATS_M1    5'h1f
`define AEC_FN_RISE         4'h0
`define AEC_FN_FALL         4'h1
`define AEC_FN_HIGH         4'h2
`define AEC_FN_LOW          4'h3
`define AEC_FN_EITHER       4'h4
`define AEC_TRIG_SRCS       5
`define AEC_CLOSE_FN_LSB    0
`define AEC_CLOSE_SEL_LSB   4
`define AEC_CLOSE_MODE_LSB  8
`define AEC_OPEN_FN_LSB     12
`define AEC_OPEN_SEL_LSB    16
`define AEC_OPEN_MODE_LSB   20
`define AEC_SYNC_LSB        24
`define AEC_VWIN_MASK       32'h0fffffff
`define AEC_MODE_SIZE       4'h0
`define AEC_MODE_TRIG       4'h1
`define AEC_SYNC_SOF        4'h1
`endif

// [design/aec_trig.v]
// Trigger source select and condition decode for window open or close
`include "aec_consts.vh"
module aec_trig (
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire [4:0] trig_in,
   input  wire [3:0] sel_in,
   input  wire [3:0] func_in,
   output reg        hit_out
);
   reg  [4:0] prev_q;
   wire       valid_sel;
   wire       cur;
   wire       prev;

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         prev_q <= 5'h00;
      end else begin
         prev_q <= trig_in;
      end
   end

   // Unsupported selections never fire
   assign valid_sel = (sel_in < `AEC_TRIG_SRCS);
   assign cur  = valid_sel & trig_in[sel_in[2:0]];
   assign prev = valid_sel & prev_q[sel_in[2:0]];

   always @* begin
      case (func_in) // see RL16
         `AEC_FN_RISE:   hit_out = cur & ~prev;
         `AEC_FN_FALL:   hit_out = ~cur & prev;
         `AEC_FN_HIGH:   hit_out = valid_sel & cur;
         `AEC_FN_LOW:    hit_out = valid_sel & ~cur;
         `AEC_FN_EITHER: hit_out = cur ^ prev;
         default:        hit_out = 1'b0;
      endcase
   end
endmodule // aec_trig

// [tb/aec_ctrl_props.sv]
// Checker for register port, sequencer state and pixel outputs
`include "aec_consts.vh"
module aec_ctrl_props (
   input wire        ref_clk_in,
   input wire        rst_in,
   input wire [7:0]  reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire        reg_wr_in,
   input wire        reg_rd_in,
   input wire [31:0] reg_rdata_out,
   input wire [3:0]  strm_valid_in,
   input wire        synth_valid_in,
   input wire        packet_fifo_overflow_in,
   input wire        pix_valid_out,
   input wire [31:0] volumes_acquired_counter_out,
   input wire [31:0] frames_acquired_counter_out,
   input wire [31:0] lines_acquired_counter_out,
   input wire [31:0] pixels_acquired_counter_out,
   input wire [2:0]  engine_nesting_state_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   chk_rdata_quiet:
      assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data not zero outside a read");
   chk_status_read:
      assert property (reg_rd_in && reg_addr_in == `AEC_OFS_STATUS |=>
         reg_rdata_out[2:0] == $past(engine_nesting_state_out) &&
         reg_rdata_out[31:5] == 27'h0 && !reg_rdata_out[3])
      else $error("status read does not match live state");
   chk_state_range:
      assert property (engine_nesting_state_out <= `AEC_ST_LINE)
      else $error("state code out of range");
   chk_ovf_to_idle:
      assert property (packet_fifo_overflow_in |=>
         engine_nesting_state_out == `AEC_ST_IDLE)
      else $error("overflow did not abort");
   chk_run_starts:
      assert property (reg_wr_in && reg_addr_in == `AEC_OFS_RUN_CTRL &&
         reg_wdata_in[3:0] == `AEC_CMD_RUN && !packet_fifo_overflow_in &&
         engine_nesting_state_out == `AEC_ST_IDLE
         |-> ##[1:2] engine_nesting_state_out == `AEC_ST_VSEQ)
      else $error("run command did not start the sequence");
   chk_clear_counts:
      assert property (reg_wr_in && reg_addr_in == `AEC_OFS_RUN_CTRL &&
         reg_wdata_in[`AEC_CLR_BIT] |=>
         volumes_acquired_counter_out == 32'h0 &&
         frames_acquired_counter_out == 32'h0 &&
         lines_acquired_counter_out == 32'h0 &&
         pixels_acquired_counter_out == 32'h0)
      else $error("counters not cleared");
   chk_pix_in_line:
      assert property (pix_valid_out |-> $past(engine_nesting_state_out)
         inside {`AEC_ST_FRM, `AEC_ST_LINE})
      else $error("pixel accepted outside a line");
   chk_pix_cause:
      assert property (pix_valid_out |->
         $past(|strm_valid_in || synth_valid_in))
      else $error("pixel without an input beat");
   chk_src_readback:
      assert property (reg_wr_in && reg_addr_in == `AEC_OFS_SRC_SEL ##1
         !reg_wr_in ##1 reg_rd_in && reg_addr_in == `AEC_OFS_SRC_SEL |=>
         reg_rdata_out == ($past(reg_wdata_in, 3) & 32'h800000ff))
      else $error("source select readback wrong");
endmodule // aec_ctrl_props

// [tb/aec_agg_model.sv]
// Stream aggregator and synthetic generator model
module aec_agg_model (
   input  wire         ref_clk_in,
   output reg  [3:0]   vld_out,
   output reg  [3:0]   sof_out,
   output reg  [3:0]   sol_out,
   output reg  [127:0] dat_out,
   output reg          s_vld_out,
   output reg          s_sof_out,
   output reg          s_sol_out,
   output reg  [31:0]  s_dat_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {vld_out, sof_out, sol_out, s_vld_out, s_sof_out, s_sol_out} = 15'h0;
      dat_out = {4{32'h5a5a5a5a}};
      s_dat_out = 32'h5a5a5a5a;
   end
   // Idle data churns so stale values never pass for a pixel
   always @(negedge ref_clk_in) begin
      if (vld_out == 4'h0) dat_out <= ~dat_out;
      if (!s_vld_out) s_dat_out <= ~s_dat_out;
   end
   // One beat held for one cycle; lane 4 is the synthetic generator
   task beat(input [2:0] ln, input f, input l, input [31:0] d);
      begin
         @(posedge ref_clk_in);
         if (ln == 3'd4) begin
            {s_vld_out, s_sof_out, s_sol_out} <= {1'b1, f, l};
            s_dat_out <= d;
         end else begin
            {vld_out[ln], sof_out[ln], sol_out[ln]} <= {1'b1, f, l};
            dat_out[32*ln +: 32] <= d;
         end
         @(posedge ref_clk_in);
         {vld_out, sof_out, sol_out, s_vld_out, s_sof_out, s_sol_out} <= 15'h0;
      end
   endtask
endmodule // aec_agg_model

// [tb/acquisition_engine_control_tb.sv]
// Testbench top for the acquisition engine control block
`include "aec_consts.vh"
module acquisition_engine_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   reg          clk, rst, wr_s, rd_s, ovf, rd_pend;
   reg  [7:0]   addr;
   reg  [31:0]  wdat, seed, d;
   reg  [4:0]   trig;
   reg  [15:0]  fpv, lpf, ppl;
   wire [31:0]  rdat, pdat, vcnt, fcnt, lcnt, pcnt, sdat;
   wire [3:0]   svld, ssof, ssol;
   wire [127:0] sd;
   wire         xv, xf, xl, pv;
   wire [2:0]   st;
   reg  [31:0]  rd_q[$];
   reg  [31:0]  pix_q[$];
   integer      failures, n_checks, k;
   aec_agg_model i_agg (.ref_clk_in(clk), .vld_out(svld), .sof_out(ssof),
      .sol_out(ssol), .dat_out(sd), .s_vld_out(xv), .s_sof_out(xf),
      .s_sol_out(xl), .s_dat_out(sdat));
   aec_top i_dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wdat), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_rdata_out(rdat), .strm_valid_in(svld), .strm_sof_in(ssof),
      .strm_sol_in(ssol), .strm_data_in(sd), .synth_valid_in(xv),
      .synth_sof_in(xf), .synth_sol_in(xl), .synth_data_in(sdat),
      .trig_in(trig), .frames_per_volume_in(fpv), .lines_per_frame_in(lpf),
      .pixels_per_line_in(ppl), .packet_fifo_overflow_in(ovf),
      .pix_valid_out(pv), .pix_data_out(pdat),
      .volumes_acquired_counter_out(vcnt), .frames_acquired_counter_out(fcnt),
      .lines_acquired_counter_out(lcnt), .pixels_acquired_counter_out(pcnt),
      .engine_nesting_state_out(st));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task finish_test;
      begin
         if (failures == 0 && n_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge clk);
         {wr_s, addr, wdat} <= {1'b1, a, v};
         @(posedge clk);
         wr_s <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         {rd_s, addr} <= {1'b1, a};
         rd_q.push_back(exp);
         @(posedge clk);
         rd_s <= 1'b0;
      end
   endtask
   task px(input [2:0] ln, input f, input l, input keep);
      begin
         d = $random(seed);
         if (keep) pix_q.push_back(d);
         i_agg.beat(ln, f, l, d);
      end
   endtask
   task wait_idle;
      integer t;
      begin
         t = 0;
         while (st !== 3'd0 && t < 200) begin
            @(posedge clk);
            t = t + 1;
         end
         if (t >= 200) begin
            failures = failures + 1;
            $display("wrong value at %0t: engine never idle", $time);
            finish_test;
         end
      end
   endtask
   // Results land one cycle after their cause; oldest note is compared
   always @(posedge clk) begin
      rd_pend <= rd_s;
      if (rd_pend) check(rdat, rd_q.pop_front());
      if (pv === 1'b1)
         check(pdat, pix_q.size() ? pix_q.pop_front() : ~pdat);
   end
   initial begin
      {rst, wr_s, rd_s, ovf, rd_pend, addr, wdat, trig} = {5'h10, 45'h0};
      {fpv, lpf, ppl} = {16'h1, 16'h1, 16'h2};
      {seed, failures, n_checks} = {32'hf156675c, 64'h0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(`AEC_OFS_RUN_CTRL, 0);
      rd(`AEC_OFS_VOL_CFG, 1);
      rd(8'h14, 0);
      wr(`AEC_OFS_SRC_SEL, 32'hffffffff);
      rd(`AEC_OFS_SRC_SEL, 32'h800000ff);
      wr(`AEC_OFS_VOL_CFG, 32'hffffffff);
      wr(`AEC_OFS_VWIN_CTRL, 32'hffffffff);
      wr(`AEC_OFS_RUN_CTRL, 32'hfffffdf0);
      rd(`AEC_OFS_VOL_CFG, 32'hffff);
      rd(`AEC_OFS_VWIN_CTRL, 32'h0fffffff);
      rd(`AEC_OFS_RUN_CTRL, 0);
      // Snap-like setup opened by a rising trigger edge
      wr(`AEC_OFS_SRC_SEL, 0);
      wr(`AEC_OFS_VWIN_CTRL, 32'h00100000);
      wr(`AEC_OFS_VOL_CFG, 1);
      wr(`AEC_OFS_RUN_CTRL, `AEC_CMD_RUN);
      repeat (6) @(posedge clk);
      rd(`AEC_OFS_STATUS, `AEC_ST_VSEQ);
      trig <= 5'h1;
      repeat (4) @(posedge clk);
      rd(`AEC_OFS_STATUS, `AEC_ST_FRM);
      px(0, 0, 1, 1);
      px(0, 0, 0, 1);
      wait_idle;
      rd(`AEC_OFS_RUN_CTRL, `AEC_CMD_RUN);
      check(pcnt, 2);
      check(lcnt, 1);
      wr(`AEC_OFS_RUN_CTRL, 32'h200);
      @(negedge clk);
      check(pcnt | lcnt | fcnt | vcnt, 0);
      // Start-of-frame sync on aggregator 2; total locked while running
      wr(`AEC_OFS_SRC_SEL, 2);
      wr(`AEC_OFS_VWIN_CTRL, 32'h01000000);
      wr(`AEC_OFS_RUN_CTRL, `AEC_CMD_RUN);
      wr(`AEC_OFS_VOL_CFG, 5);
      px(2, 0, 1, 0);
      px(0, 1, 0, 0);
      px(2, 1, 0, 0);
      px(2, 0, 1, 1);
      px(2, 0, 0, 1);
      wait_idle;
      rd(`AEC_OFS_VOL_CFG, 1);
      // Endless synthetic run, each stop level given mid-line
      wr(`AEC_OFS_SRC_SEL, 32'h80000000);
      wr(`AEC_OFS_VWIN_CTRL, 0);
      wr(`AEC_OFS_VOL_CFG, 32'hffff);
      for (k = 0; k < 5; k = k + 1) begin
         wr(`AEC_OFS_RUN_CTRL, `AEC_CMD_RUN);
         // Frame window opens two edges after the start
         repeat (2) @(posedge clk);
         px(4, 0, 1, 1);
         px(4, 0, 0, 1);
         repeat (6) @(posedge clk);
         rd(`AEC_OFS_STATUS, `AEC_ST_FRM);
         px(4, 0, 1, 1);
         wr(`AEC_OFS_RUN_CTRL, k < 4 ? k + 2 : 0);
         px(4, 0, 0, 1);
         wait_idle;
         rd(`AEC_OFS_RUN_CTRL, k < 4 ? k + 2 : 0);
      end
      // Volume held open until source 1 is high, then closes at frame end
      wr(`AEC_OFS_VOL_CFG, 1);
      wr(`AEC_OFS_VWIN_CTRL, 32'h00000112);
      wr(`AEC_OFS_RUN_CTRL, 32'h201);
      repeat (2) @(posedge clk);
      px(4, 0, 1, 1);
      px(4, 0, 0, 1);
      repeat (6) @(posedge clk);
      rd(`AEC_OFS_STATUS, `AEC_ST_FRM);
      trig <= 5'h3;
      px(4, 0, 1, 1);
      px(4, 0, 0, 1);
      wait_idle;
      check(fcnt, 2);
      check(vcnt, 1);
      wr(`AEC_OFS_RUN_CTRL, `AEC_CMD_RUN);
      repeat (4) @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      rd(`AEC_OFS_STATUS, 32'h10);
      repeat (3) @(posedge clk);
      check(pix_q.size(), 0);
      finish_test;
   end
endmodule // acquisition_engine_control_tb
bind aec_top aec_ctrl_props i_props (.ref_clk_in(ref_clk_in),
   .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .strm_valid_in(strm_valid_in),
   .synth_valid_in(synth_valid_in),
   .packet_fifo_overflow_in(packet_fifo_overflow_in),
   .pix_valid_out(pix_valid_out),
   .volumes_acquired_counter_out(volumes_acquired_counter_out),
   .frames_acquired_counter_out(frames_acquired_counter_out),
   .lines_acquired_counter_out(lines_acquired_counter_out),
   .pixels_acquired_counter_out(pixels_acquired_counter_out),
   .engine_nesting_state_out(engine_nesting_state_out));
